// ---- hw/hyst_compare.sv ----
// Magnitude comparator with separate switch-on and switch-off limits.
// Assumes limits are stable between samples and off_lim >= on_lim.
`timescale 1ns/1ps
module hyst_compare #(
    parameter bit STRICT_ON = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sample strobe and operands
    input wire logic en,
    input wire logic [16:0] value,
    input wire logic [16:0] on_lim,
    input wire logic [16:0] off_lim,
    // Result
    output logic flag
);
    logic on_hit;

    assign on_hit = STRICT_ON ? (value < on_lim) : (value <= on_lim);

    // Flag moves only past the outer limits
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (en) begin
            if (flag && (value > off_lim)) begin
                flag <= 1'b0;
            end else if (!flag && on_hit) begin
                flag <= 1'b1;
            end
        end
    end
endmodule

// ---- hw/ms_tick.sv ----
// Millisecond enable divider from the system clock.
// Assumes CYCLES is at least two.
`timescale 1ns/1ps
module ms_tick #(
    parameter int CYCLES = status_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // One-cycle pulse per period
    output logic tick
);
    logic [31:0] cnt_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_r == 32'(CYCLES - 1)) begin
            cnt_r <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// ---- hw/servo_status_detect.sv ----
// Servo status detector: in-position, zero-speed, speed match, excess.
// Assumes an APB master, synchronous inputs and a sample strobe.
//
// Operation
// - In-position window 0..262144, default 10, is the deviation threshold.
// - Unit select chooses encoder-unit deviation for window and excess limit.
// - Mode 0: flag on whenever deviation is below the window.
// - Mode 1: flag on only with no command and deviation below window.
// - Mode 2: also needs the zero-speed flag on.
// - Mode 3: latch on until next command, then keep on for hold time.
// - Mode 3: after hold expires, follow command and deviation again.
// - Hold time 0..30000 ms, used only in mode 3.
// - Hold time zero keeps latched flag until next command only.
// - Nonzero hold keeps flag that many ms; a new command clears it early.
// - Zero-speed flag when speed below level 10..20000, default 50.
// - Zero-speed uses speed magnitude, both directions alike.
// - Zero-speed has 10 r/min hysteresis.
// - Speed match when command-speed difference within band, default 50.
// - Speed match on at band minus 10, off above band plus 10.
`timescale 1ns/1ps
module servo_status_detect #(
    parameter int MS_CYCLES = status_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Servo loop inputs
    input wire logic SAMPLE,
    input wire logic CMD_PRESENT,
    input wire logic signed [31:0] DEV_CMD_UNITS,
    input wire logic signed [31:0] DEV_ENC_UNITS,
    input wire logic signed [15:0] MOTOR_SPEED,
    input wire logic signed [15:0] SPEED_CMD,
    // Status outputs
    output logic IN_POSITION,
    output logic ZERO_SPEED,
    output logic SPEED_MATCH,
    output logic DEV_EXCESS,
    output logic IRQ
);
    localparam int WIN_W = status_pkg::WIN_W;
    localparam int HOLD_W = status_pkg::HOLD_W;
    localparam int SPD_W = status_pkg::SPD_W;
    localparam int EXC_W = status_pkg::EXC_W;
    localparam int NUM_EV = status_pkg::NUM_EV;

    // Saturate a written value into its legal range
    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        logic [31:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // Magnitude of a signed word
    function automatic logic [31:0] mag32(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction

    // Registers
    status_pkg::inpos_mode_t mode_r;
    logic unit_enc_r;
    logic [WIN_W-1:0] window_r;
    logic [HOLD_W-1:0] hold_r;
    logic [SPD_W-1:0] zero_level_r;
    logic [SPD_W-1:0] band_r;
    logic [EXC_W-1:0] excess_lim_r;
    logic [NUM_EV-1:0] irq_stat_r;
    logic [NUM_EV-1:0] irq_mask_r;

    // Bus and datapath signals
    logic setup_acc;
    logic wr_done;
    logic hit;
    logic [31:0] rd_mux;
    logic [31:0] abs_dev;
    logic below;
    logic [SPD_W-1:0] abs_speed;
    logic signed [17:0] speed_diff;
    logic [SPD_W-1:0] abs_diff;
    logic zero_speed_flag;
    logic match;
    logic ms;
    logic cmd_prev_r;
    logic cmd_edge;
    logic inpos_r;
    logic inpos_nxt;
    logic excess_r;
    status_pkg::inpos_state_t st_r;
    status_pkg::inpos_state_t st_nxt;
    logic load_hold;
    logic [HOLD_W-1:0] timer_r;
    logic [NUM_EV-1:0] flags;
    logic [NUM_EV-1:0] flags_d_r;
    logic [NUM_EV-1:0] events;
    logic [NUM_EV-1:0] irq_stat_nxt;

    // APB handshake: answer one cycle into the access phase
    assign setup_acc = PSEL && PENABLE && !PREADY;
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;

    // Address decode and read data
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0;
        unique case (PADDR)
            status_pkg::ADDR_CTRL: begin
                rd_mux[status_pkg::CTRL_MODE_LSB +: 2] = mode_r;
                rd_mux[status_pkg::CTRL_UNIT_BIT] = unit_enc_r;
            end
            status_pkg::ADDR_WINDOW: rd_mux[WIN_W-1:0] = window_r;
            status_pkg::ADDR_HOLD: rd_mux[HOLD_W-1:0] = hold_r;
            status_pkg::ADDR_ZERO: rd_mux[SPD_W-1:0] = zero_level_r;
            status_pkg::ADDR_BAND: rd_mux[SPD_W-1:0] = band_r;
            status_pkg::ADDR_EXCESS: rd_mux[EXC_W-1:0] = excess_lim_r;
            status_pkg::ADDR_STATUS: begin
                rd_mux[NUM_EV-1:0] = flags;
                rd_mux[status_pkg::STAT_STATE_LSB +: 3] = st_r;
            end
            status_pkg::ADDR_IRQ_STAT: rd_mux[NUM_EV-1:0] = irq_stat_r;
            status_pkg::ADDR_IRQ_MASK: rd_mux[NUM_EV-1:0] = irq_mask_r;
            default: hit = 1'b0;
        endcase
    end

    // APB answer
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
        end else if (setup_acc) begin
            PREADY <= 1'b1;
            PRDATA <= PWRITE ? 32'h0 : rd_mux;
            PSLVERR <= !hit;
        end else begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
        end
    end

    // Setting registers
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            mode_r <= status_pkg::MODE_ANY;
            unit_enc_r <= 1'b0;
            window_r <= status_pkg::WINDOW_RST;
            hold_r <= status_pkg::HOLD_RST;
            zero_level_r <= status_pkg::ZERO_RST;
            band_r <= status_pkg::BAND_RST;
            excess_lim_r <= status_pkg::EXCESS_RST;
            irq_mask_r <= '0;
        end else if (wr_done) begin
            unique case (PADDR)
                status_pkg::ADDR_CTRL: begin
                    mode_r <= status_pkg::inpos_mode_t'(
                        PWDATA[status_pkg::CTRL_MODE_LSB +: 2]);
                    unit_enc_r <= PWDATA[status_pkg::CTRL_UNIT_BIT];
                end
                status_pkg::ADDR_WINDOW: begin
                    window_r <= WIN_W'(clamp(PWDATA, 32'h0,
                                             status_pkg::WINDOW_MAX));
                end
                status_pkg::ADDR_HOLD: begin
                    hold_r <= HOLD_W'(clamp(PWDATA, 32'h0,
                                            status_pkg::HOLD_MAX));
                end
                status_pkg::ADDR_ZERO: begin
                    zero_level_r <= SPD_W'(clamp(PWDATA, status_pkg::LEVEL_MIN,
                                                status_pkg::LEVEL_MAX));
                end
                status_pkg::ADDR_BAND: begin
                    band_r <= SPD_W'(clamp(PWDATA, status_pkg::LEVEL_MIN,
                                           status_pkg::LEVEL_MAX));
                end
                status_pkg::ADDR_EXCESS: excess_lim_r <= PWDATA[EXC_W-1:0];
                status_pkg::ADDR_IRQ_MASK: irq_mask_r <= PWDATA[NUM_EV-1:0];
                default: begin
                end
            endcase
        end
    end

    // Deviation in the selected unit
    assign abs_dev = unit_enc_r ? mag32(DEV_ENC_UNITS)
                                : mag32(DEV_CMD_UNITS);
    assign below = abs_dev < 32'(window_r);

    // Speed magnitude and command difference
    assign abs_speed = MOTOR_SPEED[15] ? SPD_W'(-32'(MOTOR_SPEED))
                                       : SPD_W'(MOTOR_SPEED);
    assign speed_diff = 18'(SPEED_CMD) - 18'(MOTOR_SPEED);
    assign abs_diff = speed_diff[17] ? SPD_W'(-speed_diff)
                                     : SPD_W'(speed_diff);

    // Zero-speed with hysteresis
    hyst_compare #(
        .STRICT_ON(1'b1)
    ) u_zero (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .en(SAMPLE),
        .value(abs_speed),
        .on_lim(zero_level_r - status_pkg::HYST),
        .off_lim(zero_level_r + status_pkg::HYST),
        .flag(zero_speed_flag)
    );

    // Speed match with hysteresis
    hyst_compare #(
        .STRICT_ON(1'b0)
    ) u_match (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .en(SAMPLE),
        .value(abs_diff),
        .on_lim(band_r - status_pkg::HYST),
        .off_lim(band_r + status_pkg::HYST),
        .flag(match)
    );

    // Millisecond time base
    ms_tick #(
        .CYCLES(MS_CYCLES)
    ) u_ms (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .tick(ms)
    );

    assign cmd_edge = CMD_PRESENT && !cmd_prev_r;

    // In-position decision
    always_comb begin
        st_nxt = st_r;
        inpos_nxt = inpos_r;
        load_hold = 1'b0;
        unique case (mode_r)
            status_pkg::MODE_ANY: begin
                st_nxt = status_pkg::S_TRACK;
                inpos_nxt = below;
            end
            status_pkg::MODE_NO_CMD: begin
                st_nxt = status_pkg::S_TRACK;
                inpos_nxt = below && !CMD_PRESENT;
            end
            status_pkg::MODE_STILL: begin
                st_nxt = status_pkg::S_TRACK;
                inpos_nxt = below && !CMD_PRESENT && zero_speed_flag;
            end
            status_pkg::MODE_LATCH: begin
                unique case (st_r)
                    status_pkg::S_TRACK: begin
                        inpos_nxt = below && !CMD_PRESENT;
                        if (below && !CMD_PRESENT) begin
                            st_nxt = status_pkg::S_LATCH;
                        end
                    end
                    status_pkg::S_LATCH: begin
                        inpos_nxt = 1'b1;
                        if (CMD_PRESENT && (hold_r == '0)) begin
                            inpos_nxt = 1'b0;
                            st_nxt = status_pkg::S_TRACK;
                        end else if (CMD_PRESENT) begin
                            load_hold = 1'b1;
                            st_nxt = status_pkg::S_HOLD;
                        end
                    end
                    status_pkg::S_HOLD: begin
                        inpos_nxt = 1'b1;
                        if (cmd_edge) begin
                            inpos_nxt = 1'b0;
                            st_nxt = status_pkg::S_TRACK;
                        end else if (timer_r == '0) begin
                            inpos_nxt = below && !CMD_PRESENT;
                            st_nxt = status_pkg::S_TRACK;
                        end
                    end
                    default: begin
                        inpos_nxt = 1'b0;
                        st_nxt = status_pkg::S_TRACK;
                    end
                endcase
            end
        endcase
    end

    // Flag and state update per sample
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            st_r <= status_pkg::S_TRACK;
            inpos_r <= 1'b0;
            cmd_prev_r <= 1'b0;
            excess_r <= 1'b0;
        end else if (SAMPLE) begin
            st_r <= st_nxt;
            inpos_r <= inpos_nxt;
            cmd_prev_r <= CMD_PRESENT;
            excess_r <= abs_dev > 32'(excess_lim_r);
        end
    end

    // Hold timer on the millisecond base
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            timer_r <= '0;
        end else if (SAMPLE && load_hold) begin
            timer_r <= hold_r;
        end else if ((st_r == status_pkg::S_HOLD) && ms && (timer_r != '0)) begin
            timer_r <= timer_r - HOLD_W'(1);
        end
    end

    // Rising flags become events; set beats write-one-clear
    assign flags = {excess_r, match, zero_speed_flag, inpos_r};
    assign events = flags & ~flags_d_r;

    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (wr_done && (PADDR == status_pkg::ADDR_IRQ_STAT)) begin
            irq_stat_nxt = irq_stat_nxt & ~PWDATA[NUM_EV-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | events;
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            flags_d_r <= '0;
            irq_stat_r <= '0;
            IRQ <= 1'b0;
        end else begin
            flags_d_r <= flags;
            irq_stat_r <= irq_stat_nxt;
            IRQ <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Status pins
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            IN_POSITION <= 1'b0;
            ZERO_SPEED <= 1'b0;
            SPEED_MATCH <= 1'b0;
            DEV_EXCESS <= 1'b0;
        end else begin
            IN_POSITION <= inpos_r;
            ZERO_SPEED <= zero_speed_flag;
            SPEED_MATCH <= match;
            DEV_EXCESS <= excess_r;
        end
    end

    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    a_mode0_window: assert property (
        SAMPLE && (mode_r == status_pkg::MODE_ANY) |=> inpos_r == $past(below))
        else $error("mode 0 flag does not follow window");

    a_mode1_command: assert property (
        SAMPLE && (mode_r == status_pkg::MODE_NO_CMD) && CMD_PRESENT
        |=> !inpos_r ##1 !IN_POSITION)
        else $error("mode 1 flag on with command present");

    a_mode2_still: assert property (
        SAMPLE && (mode_r == status_pkg::MODE_STILL) && !zero_speed_flag |=> !inpos_r)
        else $error("mode 2 flag on without zero speed");

    a_latch_holds: assert property (
        SAMPLE && (mode_r == status_pkg::MODE_LATCH)
        && (st_r == status_pkg::S_LATCH) && !CMD_PRESENT |=> inpos_r)
        else $error("latched flag dropped without command");

    a_hold_zero: assert property (
        SAMPLE && (mode_r == status_pkg::MODE_LATCH) && CMD_PRESENT
        && (st_r == status_pkg::S_LATCH) && (hold_r == '0)
        |=> !inpos_r && (st_r == status_pkg::S_TRACK))
        else $error("zero hold did not release on command");

    a_hold_load: assert property (
        SAMPLE && (mode_r == status_pkg::MODE_LATCH) && CMD_PRESENT
        && (st_r == status_pkg::S_LATCH) && (hold_r != '0)
        |=> inpos_r && (timer_r == $past(hold_r)))
        else $error("hold time not loaded");

    a_hold_expire: assert property (
        SAMPLE && (st_r == status_pkg::S_HOLD) && (timer_r == '0)
        && (mode_r == status_pkg::MODE_LATCH) |=> st_r == status_pkg::S_TRACK)
        else $error("hold did not end at zero");

    a_zero_release: assert property (
        SAMPLE && (abs_speed > zero_level_r + status_pkg::HYST) |=> !zero_speed_flag)
        else $error("zero speed kept above upper limit");

    a_match_set: assert property (
        SAMPLE && (abs_diff <= band_r - status_pkg::HYST) |=> match)
        else $error("speed match not set inside band");

    a_irq_level: assert property (
        |(irq_stat_r & irq_mask_r) |=> IRQ)
        else $error("interrupt missing for unmasked status");
endmodule

// ---- hw/status_pkg.sv ----
// Constants, register map and types for the servo status detector.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
package status_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WINDOW = 8'h04;
    localparam logic [7:0] ADDR_HOLD = 8'h08;
    localparam logic [7:0] ADDR_ZERO = 8'h0c;
    localparam logic [7:0] ADDR_BAND = 8'h10;
    localparam logic [7:0] ADDR_EXCESS = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    // Field widths
    localparam int WIN_W = 19;
    localparam int HOLD_W = 15;
    localparam int SPD_W = 17;
    localparam int EXC_W = 28;
    localparam int NUM_EV = 4;
    // Limits and reset values
    localparam logic [31:0] WINDOW_MAX = 32'h0004_0000;
    localparam logic [WIN_W-1:0] WINDOW_RST = 19'h0000a;
    localparam logic [31:0] HOLD_MAX = 32'h0000_7530;
    localparam logic [HOLD_W-1:0] HOLD_RST = 15'h0000;
    localparam logic [31:0] LEVEL_MIN = 32'h0000_000a;
    localparam logic [31:0] LEVEL_MAX = 32'h0000_4e20;
    localparam logic [SPD_W-1:0] ZERO_RST = 17'h00032;
    localparam logic [SPD_W-1:0] BAND_RST = 17'h00032;
    localparam logic [SPD_W-1:0] HYST = 17'h0000a;
    localparam logic [EXC_W-1:0] EXCESS_RST = 28'h00186a0;
    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_UNIT_BIT = 2;
    // Status and event bit positions
    localparam int EV_INPOS = 0;
    localparam int EV_ZERO = 1;
    localparam int EV_MATCH = 2;
    localparam int EV_EXCESS = 3;
    localparam int STAT_STATE_LSB = 4;
    // Time base
    localparam int CLK_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;

    typedef enum logic [1:0] {
        MODE_ANY = 2'h0,
        MODE_NO_CMD = 2'h1,
        MODE_STILL = 2'h2,
        MODE_LATCH = 2'h3
    } inpos_mode_t;

    typedef enum logic [2:0] {
        S_TRACK = 3'h1,
        S_LATCH = 3'h2,
        S_HOLD = 3'h4
    } inpos_state_t;
endpackage

// ---- tb/servo_host_model.sv ----
// Host-side model: issues the sample strobe and the servo loop values.
// Assumes the bench sets targets; they reach the detector a clock later.
`timescale 1ns/1ps
module servo_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Targets from the bench
    input wire logic cmd_t,
    input wire logic signed [31:0] dev_t,
    input wire logic signed [31:0] enc_t,
    input wire logic signed [15:0] spd_t,
    input wire logic signed [15:0] scmd_t,
    // Toward the detector
    output logic sample,
    output logic cmd,
    output logic signed [31:0] dev,
    output logic signed [31:0] enc,
    output logic signed [15:0] spd,
    output logic signed [15:0] scmd
);
    logic [1:0] cnt_r;
    // One control sample every fourth clock
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 2'h0;
            sample <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            sample <= (cnt_r == 2'h3);
        end
    end
    // Loop values follow the targets
    always_ff @(posedge clk) begin
        cmd <= cmd_t;
        dev <= dev_t;
        enc <= enc_t;
        spd <= spd_t;
        scmd <= scmd_t;
    end
endmodule

// ---- tb/test_servo_status_detect.sv ----
// Self-checking bench for the servo status detector.
// Assumes the host model file; register reads are checked by a monitor.
`timescale 1ns/1ps
module test_servo_status_detect;
    typedef struct {string name; logic [31:0] exp; logic [31:0] mask; logic err;} note_t;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sample, cmd, inpos, zpin, match, excess, irq;
    logic cmd_t = 1'b0;
    logic signed [31:0] dev_t = 0, enc_t = 0, dev, enc;
    logic signed [15:0] spd_t = 0, scmd_t = 0, spd, scmd;
    int fails = 0, compares = 0;
    note_t q[$];
    note_t cur;
    logic signed [15:0] zs[7] = '{100, 39, 55, -55, 61, -45, -39};
    logic [31:0] zx[7] = '{0, 2, 2, 2, 0, 0, 2};
    logic signed [15:0] ms[5] = '{500, 440, 439, 545, 540};
    logic [31:0] mx[5] = '{4, 4, 0, 0, 4};

    always #12.5 clk = ~clk;

    servo_host_model host_u (.clk(clk), .rst(rst), .cmd_t(cmd_t), .dev_t(dev_t),
        .enc_t(enc_t), .spd_t(spd_t), .scmd_t(scmd_t), .sample(sample), .cmd(cmd),
        .dev(dev), .enc(enc), .spd(spd), .scmd(scmd));

    servo_status_detect #(.MS_CYCLES(10)) dut_u (.CLK_SYS(clk), .SYS_RST(rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SAMPLE(sample), .CMD_PRESENT(cmd), .DEV_CMD_UNITS(dev), .DEV_ENC_UNITS(enc),
        .MOTOR_SPEED(spd), .SPEED_CMD(scmd), .IN_POSITION(inpos), .ZERO_SPEED(zpin),
        .SPEED_MATCH(match), .DEV_EXCESS(excess), .IRQ(irq));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Read results are taken at the edge that completes the access
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            cur = q.pop_front();
            check(cur.name, prdata & cur.mask, cur.exp);
            check("slverr", {31'h0, pslverr}, {31'h0, cur.err});
        end
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic err);
        q.push_back('{s, e, m, err});
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic set(input logic c, input int d, input int s);
        cmd_t <= c;
        dev_t <= d;
        spd_t <= 16'(s);
        repeat (16) @(posedge clk);
    endtask

    task automatic pos_chk(input logic [31:0] e);
        rd("inpos", status_pkg::ADDR_STATUS, e, 32'h1, 1'b0);
        check("inpos pin", {31'h0, inpos}, e);
    endtask

    initial begin
        #500000;
        fails++;
        finish_test;
    end

    initial begin
        void'($urandom(50));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd("window", status_pkg::ADDR_WINDOW, 32'(status_pkg::WINDOW_RST), '1, 0);
        rd("hold", status_pkg::ADDR_HOLD, 32'(status_pkg::HOLD_RST), '1, 0);
        rd("zlevel", status_pkg::ADDR_ZERO, 32'(status_pkg::ZERO_RST), '1, 0);
        rd("band", status_pkg::ADDR_BAND, 32'(status_pkg::BAND_RST), '1, 0);
        rd("unmapped", 8'h3c, 32'h0, '1, 1'b1);
        wr(status_pkg::ADDR_WINDOW, 32'h000fffff);
        rd("window", status_pkg::ADDR_WINDOW, status_pkg::WINDOW_MAX, '1, 0);
        wr(status_pkg::ADDR_HOLD, 32'h0000ffff);
        rd("hold", status_pkg::ADDR_HOLD, status_pkg::HOLD_MAX, '1, 0);
        wr(status_pkg::ADDR_ZERO, 32'h00000005);
        rd("zlevel", status_pkg::ADDR_ZERO, status_pkg::LEVEL_MIN, '1, 0);
        wr(status_pkg::ADDR_ZERO, 32'h00000032);
        wr(status_pkg::ADDR_WINDOW, 32'h0000000a);
        wr(status_pkg::ADDR_HOLD, 32'h00000000);
        $display("done: registers");
        for (int i = 0; i < 4; i++) begin
            set(1'b1, $urandom_range(9, 0) * ((i % 2) ? -1 : 1), 0);
            pos_chk(32'h1);
        end
        set(1'b0, 10, 0);
        pos_chk(32'h0);
        set(1'b0, -10, 0);
        pos_chk(32'h0);
        enc_t <= 3;
        wr(status_pkg::ADDR_CTRL, 32'h00000004);
        set(1'b0, 1000, 0);
        pos_chk(32'h1);
        wr(status_pkg::ADDR_CTRL, 32'h00000001);
        set(1'b1, 3, 0);
        pos_chk(32'h0);
        set(1'b0, 3, 0);
        pos_chk(32'h1);
        wr(status_pkg::ADDR_CTRL, 32'h00000002);
        set(1'b0, 3, 100);
        pos_chk(32'h0);
        set(1'b0, 3, 0);
        pos_chk(32'h1);
        $display("done: modes 0 to 2");
        for (int i = 0; i < 7; i++) begin
            set(1'b0, 3, zs[i]);
            rd("zero", status_pkg::ADDR_STATUS, zx[i], 32'h2, 0);
            check("zero pin", {31'h0, zpin}, zx[i] >> 1);
        end
        scmd_t <= 500;
        for (int i = 0; i < 5; i++) begin
            set(1'b0, 3, ms[i]);
            rd("match", status_pkg::ADDR_STATUS, mx[i], 32'h4, 0);
            check("match pin", {31'h0, match}, mx[i] >> 2);
        end
        $display("done: speed flags");
        wr(status_pkg::ADDR_CTRL, 32'h00000003);
        set(1'b0, 3, 0);
        pos_chk(32'h1);
        set(1'b0, 500, 0);
        pos_chk(32'h1);
        set(1'b1, 500, 0);
        pos_chk(32'h0);
        set(1'b0, 3, 0);
        wr(status_pkg::ADDR_HOLD, 32'h00000014);
        set(1'b1, 500, 0);
        rd("hold", status_pkg::ADDR_STATUS, 32'h41, 32'h71, 0);
        set(1'b0, 500, 0);
        pos_chk(32'h1);
        set(1'b1, 500, 0);
        pos_chk(32'h0);
        set(1'b0, 3, 0);
        wr(status_pkg::ADDR_HOLD, 32'h00000004);
        set(1'b1, 500, 0);
        repeat (60) @(posedge clk);
        pos_chk(32'h0);
        $display("done: latch and hold");
        wr(status_pkg::ADDR_EXCESS, 32'h00000064);
        set(1'b0, -101, 0);
        rd("excess", status_pkg::ADDR_STATUS, 32'h8, 32'h8, 0);
        check("excess pin", {31'h0, excess}, 32'h1);
        set(1'b0, 100, 0);
        rd("excess", status_pkg::ADDR_STATUS, 32'h0, 32'h8, 0);
        wr(status_pkg::ADDR_CTRL, 32'h00000004);
        set(1'b0, -101, 0);
        rd("excess", status_pkg::ADDR_STATUS, 32'h0, 32'h8, 0);
        check("excess pin", {31'h0, excess}, 32'h0);
        $display("done: excess");
        wr(status_pkg::ADDR_CTRL, 32'h00000000);
        wr(status_pkg::ADDR_IRQ_STAT, 32'h0000000f);
        wr(status_pkg::ADDR_IRQ_MASK, 32'h00000001);
        set(1'b0, 500, 0);
        set(1'b0, 3, 0);
        check("irq", {31'h0, irq}, 32'h1);
        rd("irqstat", status_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1, 0);
        wr(status_pkg::ADDR_IRQ_STAT, 32'h00000001);
        repeat (4) @(posedge clk);
        check("irq", {31'h0, irq}, 32'h0);
        wr(status_pkg::ADDR_IRQ_MASK, 32'h00000000);
        set(1'b0, 3, 100);
        set(1'b0, 3, 0);
        rd("irqstat", status_pkg::ADDR_IRQ_STAT, 32'h2, 32'h3, 0);
        check("irq", {31'h0, irq}, 32'h0);
        $display("done: interrupts");
        finish_test;
    end
endmodule
